// ### evflag_pkg.sv
/*
 * Package for the timer and capture/compare event flag block.
 * It holds the register map, the flag positions, the reset values and the carrier types.
 * It assumes a 32-bit classic Wishbone slave that is addressed by byte.
 */
`default_nettype none
package evflag_pkg;

    // These are the byte offsets of the three registers.
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_MASK   = 4'h4;
    localparam logic [3:0] OFF_MODE   = 4'h8;

    // These are the positions of the flags in the status and mask registers.
    localparam int BIT_OVF = 0;
    localparam int BIT_PRD = 1;
    localparam int BIT_CCP = 2;

    // These are the reset values.
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [2:0] MASK_RST  = 3'h0;

    // This answer is returned when a read hits no register.
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // These are the operating modes of the capture/compare unit.
    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_PWM,
        MODE_OFF
    } capcmp_mode_t;

    // This is the Wishbone request that the master drives.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    // These are the event pulses that come from the timers and the capture/compare logic.
    typedef struct packed {
        logic capture;
        logic compare;
        logic period_match;
        logic overflow;
    } events_t;

endpackage
`default_nettype wire

// ### evflag_bits.sv
/*
 * Sticky flag cell: a set pulse sets it and a one-cycle clear pulse clears it.
 * The set wins over a clear that arrives in the same cycle, so no event is lost.
 * It assumes that set and clear are on the same clock as the cell.
 */
`timescale 1ns/1ps
`default_nettype none
module evflag_bits #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clr,
    output var  logic [WIDTH-1:0] q
);

    // This holds the whole state of the cell.
    typedef struct packed {
        logic [WIDTH-1:0] q;
    } bits_st_t;

    bits_st_t st_r;   // The registered state.
    bits_st_t st_nxt; // The next state.

    // Each bit is set by its event and cleared by its write, and the set wins.
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < WIDTH; i++) begin
            st_nxt.q[i] = set[i] | (st_r.q[i] & ~clr[i]);
        end
    end

    // The state resets to all clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;

endmodule
`default_nettype wire

// ### timer_ccp_event_flags.sv
/*
 * Event flag block for the capture/compare unit and two timers, with a Wishbone slave.
 * It assumes the event pulses are one clk_sys cycle wide and come from logic on clk_sys.
 */
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_ccp_event_flags (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire evflag_pkg::wb_req_t     wb_req,
    output var  logic [31:0]             wb_dat_o,
    output var  logic                    wb_ack_o,
    input  wire evflag_pkg::events_t     ev,
    output var  logic                    irq
);

    // This holds the whole state of the block.
    typedef struct packed {
        logic [31:0]              rdata;
        logic                     ack;
        logic [2:0]               mask;
        evflag_pkg::capcmp_mode_t mode;
        logic                     irq;
    } top_st_t;

    top_st_t    st_r;       // The registered state.
    top_st_t    st_nxt;     // The next state.
    logic [1:0] rst_sync_r; // The reset release synchroniser.
    logic       rst_n_int;  // The synchronised reset.
    logic [2:0] flag_set;   // The flag set pulses.
    logic [2:0] flag_clr;   // The flag clear pulses from software.
    logic [2:0] flags;      // The sticky flags.
    logic       wr_go;      // A write is accepted this cycle.
    logic       ccp_hit;    // The capture/compare event that counts.

    // The reset is asserted at once and released through two flip-flops.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_r[1];

    // Only the event of the current mode may set bit 2, and PWM mode sets nothing.
    always_comb begin
        unique case (st_r.mode)
            evflag_pkg::MODE_CAPTURE: ccp_hit = ev.capture;
            evflag_pkg::MODE_COMPARE: ccp_hit = ev.compare;
            evflag_pkg::MODE_PWM:     ccp_hit = 1'b0;
            evflag_pkg::MODE_OFF:     ccp_hit = 1'b0;
        endcase
    end

    // The flag set and clear vectors.
    always_comb begin
        wr_go = wb_req.cyc & wb_req.stb & wb_req.we & ~st_r.ack;
        flag_set = 3'h0;
        flag_set[evflag_pkg::BIT_CCP] = ccp_hit;
        flag_set[evflag_pkg::BIT_PRD] = ev.period_match;
        flag_set[evflag_pkg::BIT_OVF] = ev.overflow;
        flag_clr = 3'h0;
        if (wr_go && wb_req.adr == evflag_pkg::OFF_STATUS && wb_req.sel[0]) begin
            flag_clr = wb_req.dat[2:0];
        end
    end

    // The sticky flags; the overflow bit only rises on an overflow pulse.
    evflag_bits #(
        .WIDTH (3)
    ) evflag_bits_i (
        .clk   (clk_sys),
        .rst_n (rst_n_int),
        .set   (flag_set),
        .clr   (flag_clr),
        .q     (flags)
    );

    // The bus slave answers one cycle after a request and drops ack the next cycle.
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = wb_req.cyc & wb_req.stb & ~st_r.ack;
        if (wb_req.cyc && wb_req.stb && !st_r.ack) begin
            st_nxt.rdata = evflag_pkg::UNMAPPED_DATA;
            unique case (wb_req.adr)
                evflag_pkg::OFF_STATUS: st_nxt.rdata = {29'h0, flags};
                evflag_pkg::OFF_MASK:   st_nxt.rdata = {29'h0, st_r.mask};
                evflag_pkg::OFF_MODE:   st_nxt.rdata = {30'h0, st_r.mode};
                default:                st_nxt.rdata = evflag_pkg::UNMAPPED_DATA;
            endcase
            if (wb_req.we && wb_req.sel[0]) begin
                if (wb_req.adr == evflag_pkg::OFF_MASK) begin
                    st_nxt.mask = wb_req.dat[2:0];
                end
                if (wb_req.adr == evflag_pkg::OFF_MODE) begin
                    st_nxt.mode = evflag_pkg::capcmp_mode_t'(wb_req.dat[1:0]);
                end
            end
        end
        // The interrupt follows the unmasked flags with one cycle of delay.
        st_nxt.irq = |(flags & st_r.mask);
    end

    // The state register.
    always_ff @(posedge clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_r.rdata <= 32'h0000_0000;
            st_r.ack   <= 1'b0;
            st_r.mask  <= evflag_pkg::MASK_RST;
            st_r.mode  <= evflag_pkg::MODE_CAPTURE;
            st_r.irq   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign irq      = st_r.irq;

    // The assertions watch the flags one cycle after their events.
    property p_capture;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (ev.capture && st_r.mode == evflag_pkg::MODE_CAPTURE) |=> flags[evflag_pkg::BIT_CCP];
    endproperty
    a_capture: assert property (p_capture) else $error("capture did not set flag");

    property p_compare;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (ev.compare && st_r.mode == evflag_pkg::MODE_COMPARE) |=> flags[evflag_pkg::BIT_CCP];
    endproperty
    a_compare: assert property (p_compare) else $error("compare did not set flag");

    property p_period;
        @(posedge clk_sys) disable iff (!rst_n_int)
        ev.period_match |=> flags[evflag_pkg::BIT_PRD];
    endproperty
    a_period: assert property (p_period) else $error("period match did not set flag");

    property p_ovf;
        @(posedge clk_sys) disable iff (!rst_n_int)
        ev.overflow |=> flags[evflag_pkg::BIT_OVF];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow did not set flag");

    property p_ovf_rise;
        @(posedge clk_sys) disable iff (!rst_n_int)
        $rose(flags[evflag_pkg::BIT_OVF]) |-> $past(ev.overflow);
    endproperty
    a_ovf_rise: assert property (p_ovf_rise) else $error("overflow flag rose without cause");

    property p_pwm;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (st_r.mode == evflag_pkg::MODE_PWM && !flags[evflag_pkg::BIT_CCP]) |=> !flags[evflag_pkg::BIT_CCP];
    endproperty
    a_pwm: assert property (p_pwm) else $error("flag set in pwm mode");

    property p_sticky;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (flags[evflag_pkg::BIT_PRD] && !flag_clr[evflag_pkg::BIT_PRD]) |=> flags[evflag_pkg::BIT_PRD];
    endproperty
    a_sticky: assert property (p_sticky) else $error("period flag lost without clear");

    property p_hold_ccp;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (flags[evflag_pkg::BIT_CCP] && !flag_clr[evflag_pkg::BIT_CCP]) |=> flags[evflag_pkg::BIT_CCP];
    endproperty
    a_hold_ccp: assert property (p_hold_ccp) else $error("capture flag lost without clear");

    // A clear of the overflow flag with no overflow in that cycle must empty it.
    property p_clr_ovf;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (flag_clr[evflag_pkg::BIT_OVF] && !ev.overflow) |=> !flags[evflag_pkg::BIT_OVF];
    endproperty
    a_clr_ovf: assert property (p_clr_ovf) else $error("overflow flag survived its clear");

    // A request is taken when cyc and stb stand high while ack is low.
    sequence s_take;
        wb_req.cyc && wb_req.stb && !wb_ack_o;
    endsequence

    // The answer is ack for one cycle and then ack low again.
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    // Every taken request gets exactly one ack pulse; a master that holds stb is answered again every second cycle.
    property p_bus_answer;
        @(posedge clk_sys) disable iff (!rst_n_int)
        s_take |=> s_ack_pulse;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("request not answered by one ack pulse");

    // Ack never rises unless a request stood in the cycle before.
    property p_ack_cause;
        @(posedge clk_sys) disable iff (!rst_n_int)
        $rose(wb_ack_o) |-> ($past(wb_req.cyc) && $past(wb_req.stb));
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack rose without a request");

    // A status read returns the flags as they stood at the take edge.
    property p_read_status;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (wb_req.cyc && wb_req.stb && !wb_ack_o && !wb_req.we && wb_req.adr == evflag_pkg::OFF_STATUS)
            |=> (wb_dat_o[2:0] == $past(flags));
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read differs from flags");

    // The interrupt rises one cycle after an unmasked flag is seen.
    property p_irq_on;
        @(posedge clk_sys) disable iff (!rst_n_int)
        (|(flags & st_r.mask)) |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt missing for unmasked flag");

    // The interrupt stays low while every set flag is masked off.
    property p_irq_off;
        @(posedge clk_sys) disable iff (!rst_n_int)
        !(|(flags & st_r.mask)) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without unmasked flag");

endmodule
`default_nettype wire

// ### timer_ccp_event_flags_bench.sv
/*
 * Self-checking bench for the timer and capture/compare event flag block.
 * It assumes the package and design files are compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps
`default_nettype none
module timer_ccp_event_flags_bench;
    logic                clk_sys;    // System clock at 50 MHz.
    logic                rst_n;      // Active-low reset.
    evflag_pkg::wb_req_t wb_req;     // Bus request driven by the bench.
    logic [31:0]         wb_dat_o;   // Read data from the block.
    logic                wb_ack_o;   // Bus acknowledge.
    evflag_pkg::events_t ev;         // Event pulses into the block.
    logic                irq;        // Interrupt level.
    logic [31:0]         rd;         // Word taken by the last bus cycle.
    int                  err_count;  // Mismatches seen.
    int                  n_checks;   // Comparisons made.

    timer_ccp_event_flags timer_ccp_event_flags_i (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .wb_req   (wb_req),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .ev       (ev),
        .irq      (irq)
    );

    // The clock toggles every 10 ns.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Checks made: %0d, mismatches: %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares a result word with its expected value.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One classic cycle; the wait for ack is bounded so a dead slave cannot hang the run.
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] sel = 4'hf);
        int n;
        @(posedge clk_sys);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20 && wb_ack_o !== 1'b1) begin
            err_count++;
            $display("ERROR at %0t: no ack", $time);
            results();
        end else begin
            rd = wb_dat_o;
            wb_req <= '0;
        end
    endtask

    // Reads a register and compares it.
    task automatic rdchk(input logic [3:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        chk(rd, exp, "read");
    endtask

    // Drives one cycle of events: capture, compare, period match, overflow from the top bit.
    task automatic pulse(input logic [3:0] e);
        @(posedge clk_sys);
        ev <= e;
        @(posedge clk_sys);
        ev <= '0;
    endtask

    // Samples the interrupt on falling edges, once its register has had time to follow.
    task automatic irqchk(input logic exp);
        repeat (2) @(negedge clk_sys);
        chk({31'h0, irq}, {31'h0, exp}, "irq");
    endtask

    // Main sequence.
    initial begin
        err_count = 0;
        n_checks  = 0;
        rst_n     = 1'b0;
        wb_req    = '0;
        ev        = '0;
        rd        = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk(evflag_pkg::OFF_STATUS, {29'h0, evflag_pkg::FLAGS_RST});
        rdchk(evflag_pkg::OFF_MASK, {29'h0, evflag_pkg::MASK_RST});
        rdchk(evflag_pkg::OFF_MODE, 32'h0000_0000);
        irqchk(1'b0);
        // Capture mode: the flag sticks until a one is written to it.
        pulse(4'h8);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0004);
        wb(1'b1, evflag_pkg::OFF_STATUS, 32'h0000_0003);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0004);
        wb(1'b1, evflag_pkg::OFF_STATUS, 32'h0000_0004);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0000);
        pulse(4'h4);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0000);
        // Compare mode: only a match sets the flag.
        wb(1'b1, evflag_pkg::OFF_MODE, 32'(evflag_pkg::MODE_COMPARE));
        pulse(4'h8);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0000);
        pulse(4'h4);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0004);
        wb(1'b1, evflag_pkg::OFF_STATUS, 32'h0000_0004);
        // Neither PWM nor off may set the flag.
        for (int m = 2; m < 4; m++) begin
            wb(1'b1, evflag_pkg::OFF_MODE, 32'(m));
            pulse(4'hc);
            rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0000);
        end
        pulse(4'h2);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0002);
        pulse(4'h1);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0003);
        // The interrupt follows only unmasked flags.
        wb(1'b1, evflag_pkg::OFF_MASK, 32'h0000_0001);
        irqchk(1'b1);
        wb(1'b1, evflag_pkg::OFF_MASK, 32'h0000_0004);
        irqchk(1'b0);
        rdchk(evflag_pkg::OFF_MASK, 32'h0000_0004);
        // A write with the low byte lane off must leave the mask alone.
        wb(1'b1, evflag_pkg::OFF_MASK, 32'h0000_0007, 4'he);
        rdchk(evflag_pkg::OFF_MASK, 32'h0000_0004);
        wb(1'b1, evflag_pkg::OFF_STATUS, 32'h0000_0001);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0002);
        wb(1'b1, evflag_pkg::OFF_STATUS, 32'h0000_0002);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0000);
        rdchk(4'hc, 32'h0000_0000);
        // A clear and an event in the same cycle: the event wins, so nothing is lost.
        fork
            wb(1'b1, evflag_pkg::OFF_STATUS, 32'h0000_0002);
            pulse(4'h2);
        join
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0002);
        // A reset in mid-run clears flags, mask and mode again.
        pulse(4'h1);
        rdchk(evflag_pkg::OFF_STATUS, 32'h0000_0003);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk(evflag_pkg::OFF_STATUS, {29'h0, evflag_pkg::FLAGS_RST});
        rdchk(evflag_pkg::OFF_MASK, {29'h0, evflag_pkg::MASK_RST});
        rdchk(evflag_pkg::OFF_MODE, 32'h0000_0000);
        irqchk(1'b0);
        results();
    end
endmodule
`default_nettype wire
